// ### inc/pps_cfg.svh
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// Register byte offsets
`define PPS_OFF_DEVCS      8'hC8
`define PPS_OFF_LINKCAP    8'hCC
`define PPS_OFF_IRQ_STAT   8'hE0
`define PPS_OFF_IRQ_MASK   8'hE4

// Device status field positions
`define PPS_ST_ERR_LSB     16
`define PPS_ST_AUX_BIT     20
`define PPS_ST_TP_BIT      21
`define PPS_ST_BYTE_LANE   2

// Reset values
`define PPS_RST_AUX        1'b1
`define PPS_RST_TP         1'b0
`define PPS_RST_SPEED      4'h2
`define PPS_RST_WIDTH_X2   6'h02
`define PPS_RST_WIDTH_X1   6'h01
`define PPS_RST_ASPM       2'h0
`define PPS_RST_L0S        3'h3
`define PPS_RST_L1         3'h0
`define PPS_RST_DLL        1'b0
`define PPS_RST_BWN_DN     1'b1
`define PPS_RST_BWN_UP     1'b0
`define PPS_RST_MASK       4'h0

// Number of error event sources
`define PPS_NUM_ERR        4

`endif

// ### inc/pps_pkg.sv
package pps_pkg;

  // AXI4-Lite response codes
  typedef enum logic [1:0] {
    PPS_RESP_OKAY   = 2'h0,
    PPS_RESP_SLVERR = 2'h2,
    PPS_RESP_DECERR = 2'h3
  } pps_resp_t;

  // Error flag index order in the status word
  typedef enum logic [1:0] {
    PPS_ERR_CORR,
    PPS_ERR_NONFATAL,
    PPS_ERR_FATAL,
    PPS_ERR_UNSUP
  } pps_err_t;

endpackage

// ### verif/pps_chk_properties.sv
`timescale 1ns/100ps
// Watches bus answers and register contents at the top ports
module pps_chk #(
  parameter int unsigned PORT_ID = 0
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Write response
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Events, aux sense and interrupt
  input wire logic        err_corr,
  input wire logic        err_nonfatal,
  input wire logic        err_fatal,
  input wire logic        err_unsup,
  input wire logic        aux_power_pin,
  input wire logic        irq
);
  // Any error pulse in this cycle
  logic any_err;
  // Read address taken in this cycle
  logic rd_take;
  assign any_err = err_corr | err_nonfatal | err_fatal | err_unsup;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_R_LAT: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_UNMAP: assert property (rd_take && !(s_axi_araddr inside {8'hC8, 8'hCC, 8'hE0, 8'hE4})
    |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  AST_LCAP: assert property (rd_take && s_axi_araddr == 8'hCC |=>
    s_axi_rdata[3:0] == 4'h2 && s_axi_rdata[23:18] == {2'h0, PORT_ID != 0, 3'h0}
    && s_axi_rdata[9:4] == ((PORT_ID == 0) ? 6'h02 : 6'h01)) else $error("link caps wrong");
  AST_STAT_RSVD: assert property (rd_take && s_axi_araddr == 8'hC8 |=>
    s_axi_rdata[31:21] == 11'h0 && s_axi_rdata[15:0] == 16'h0) else $error("status spare set");
  AST_AUX: assert property (rd_take && s_axi_araddr == 8'hC8 && aux_power_pin
    && $past(aux_power_pin) && $past(aux_power_pin, 2) && $past(aux_power_pin, 3)
    |=> s_axi_rdata[20]) else $error("aux power not shown");
  AST_IRQ_CLR: assert property (rd_take && s_axi_araddr == 8'hE0 && !any_err ##1 !any_err[*2]
    |=> !irq) else $error("interrupt stays after status read");
endmodule

bind pps_top pps_chk #(.PORT_ID(PORT_ID)) i_chk (.clock, .resetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .err_corr, .err_nonfatal, .err_fatal,
  .err_unsup, .aux_power_pin, .irq);

// ### verif/tb.sv
`timescale 1ns/100ps
// Self-checking bench for one downstream port
module tb;
  // Port under test
  localparam int unsigned P = 1;
  // Master side and answers
  logic        clock, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, err_corr, err_nonfatal, err_fatal, err_unsup;
  logic        aux_power_pin, ovr_valid, aux;
  // Late ready: answer is left waiting one cycle before it is taken
  logic        slow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ovr_port_num;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb, acc, clr, stb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, ovr_aspm;
  logic [2:0]  ovr_l0s, ovr_l1;
  logic [15:0] ov;
  // Tallies
  int          fail_count, cmp_count;

  // Block under test
  pps_top #(.PORT_ID(P)) i_dut (.clock, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .err_corr, .err_nonfatal, .err_fatal, .err_unsup, .aux_power_pin, .ovr_valid,
    .ovr_aspm, .ovr_l0s, .ovr_l1, .ovr_port_num, .irq);

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Verdict and end of run
  task complete_run;
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  // Write: each half released when taken, response awaited, bready late if slow
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'h3, ~slow};
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read: address released when taken, data taken at the rready edge
  task rd(input logic [7:0] a);
    @(posedge clock);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {1'b1, ~slow, a};
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    {rd_d, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle error pulses
  task pulse(input logic [3:0] e);
    @(posedge clock);
    {err_unsup, err_fatal, err_nonfatal, err_corr} <= e;
    @(posedge clock);
    {err_unsup, err_fatal, err_nonfatal, err_corr} <= 4'h0;
  endtask

  // Expected link capabilities word
  function automatic logic [31:0] lcap(input logic [1:0] asp, input logic [2:0] l0,
    input logic [2:0] l1, input logic [7:0] pn);
    return {pn, 2'h0, P != 0, 1'b0, 2'h0, l1, l0, asp, (P == 0) ? 6'h02 : 6'h01, 4'h2};
  endfunction

  // Expected status word, control half reads zero
  function automatic logic [31:0] stat(input logic [3:0] e, input logic a);
    return {11'h000, a, e, 16'h0000};
  endfunction

  // Hang guard, far beyond the expected run
  initial
  begin
    #100000;
    fail_count++;
    complete_run;
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {err_unsup, err_fatal, err_nonfatal, err_corr, ovr_valid, resetn} = 6'h00;
    {ovr_aspm, ovr_l0s, ovr_l1, ovr_port_num} = '0;
    {aux_power_pin, fail_count, cmp_count} = {1'b1, 32'h0, 32'h0};
    slow = 1'b0;
    void'($urandom(59340));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rd(8'hCC);
    chk("lcap_rst", rd_d, lcap(2'h0, 3'h3, 3'h0, P[7:0]));
    rd(8'hC8);
    chk("stat_rst", rd_d, stat(4'h0, 1'b1));
    acc = 4'h0;
    // Random events, partial clears, ones into spare bits
    repeat (10)
    begin
      aux = 1'($urandom);
      aux_power_pin <= aux;
      slow = 1'($urandom);
      stb = 4'($urandom);
      pulse(stb);
      acc = acc | stb;
      repeat (2) @(posedge clock);
      rd(8'hC8);
      chk("stat_set", rd_d, stat(acc, aux));
      {clr, stb} = 8'($urandom);
      wr(8'hC8, {12'hFFF, clr, 16'hFFFF}, stb);
      if (stb[2])
        acc = acc & ~clr;
      rd(8'hC8);
      chk("stat_clr", rd_d, stat(acc, aux));
    end
    // Interrupt raised, cleared by read, then masked
    wr(8'hE4, 32'h0000000F, 4'hF);
    rd(8'hE0);
    pulse(4'h4);
    repeat (2) @(posedge clock);
    chk("irq_on", {31'h0, irq}, 32'h1);
    rd(8'hE0);
    chk("irq_stat", rd_d, 32'h4);
    repeat (3) @(posedge clock);
    chk("irq_off", {31'h0, irq}, 32'h0);
    wr(8'hE4, 32'h0000000B, 4'hF);
    pulse(4'h4);
    repeat (2) @(posedge clock);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    // Loader override of capability defaults
    ov = 16'($urandom);
    @(posedge clock);
    {ovr_valid, ovr_aspm, ovr_l0s, ovr_l1, ovr_port_num} <= {1'b1, ov};
    @(posedge clock);
    ovr_valid <= 1'b0;
    wr(8'hCC, 32'hFFFFFFFF, 4'hF);
    chk("bresp_ro", {30'h0, rsp}, 32'h0);
    rd(8'hCC);
    chk("lcap_ovr", rd_d, lcap(ov[15:14], ov[13:11], ov[10:8], ov[7:0]));
    // Unmapped places
    wr(8'h40, 32'h0, 4'hF);
    chk("bresp_un", {30'h0, rsp}, {30'h0, pps_pkg::PPS_RESP_DECERR});
    rd(8'h44);
    chk("rdata_un", {rd_d[31:2], rsp}, {30'h0, pps_pkg::PPS_RESP_DECERR});
    // Second reset restores defaults
    @(posedge clock);
    aux_power_pin <= 1'b1;
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(8'hCC);
    chk("lcap_rst2", rd_d, lcap(2'h0, 3'h3, 3'h0, P[7:0]));
    chk("irq_rst2", {31'h0, irq}, 32'h0);
    rd(8'hC8);
    chk("stat_rst2", rd_d, stat(4'h0, 1'b1));
    rd(8'hE0);
    chk("irq_stat_rst2", rd_d, 32'h0);
    complete_run;
  end
endmodule

// ### verilog/pps_sync2.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a level from outside the clock domain
module pps_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_q
);

  logic meta_q;  // First stage, read only by second stage

  // Both stages reset to the same value so no false edge leaves reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

// ### verilog/pps_top.sv
`timescale 1ns/100ps
`include "pps_cfg.svh"
module pps_top #(
  parameter int unsigned PORT_ID = 0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Error detection pulses from the port core
  input  wire logic        err_corr,
  input  wire logic        err_nonfatal,
  input  wire logic        err_fatal,
  input  wire logic        err_unsup,
  // Aux power sense pin
  input  wire logic        aux_power_pin,
  // Capability override from SMBus or EEPROM loader
  input  wire logic        ovr_valid,
  input  wire logic [1:0]  ovr_aspm,
  input  wire logic [2:0]  ovr_l0s,
  input  wire logic [2:0]  ovr_l1,
  input  wire logic [7:0]  ovr_port_num,
  // Interrupt
  output logic             irq
);

  localparam int NE = `PPS_NUM_ERR;  // Error sources

  // Port dependent reset values, fixed at elaboration
  localparam logic [5:0] RST_WIDTH = (PORT_ID == 0) ? `PPS_RST_WIDTH_X2 : `PPS_RST_WIDTH_X1;
  localparam logic       RST_BWN   = (PORT_ID == 0) ? `PPS_RST_BWN_UP : `PPS_RST_BWN_DN;
  localparam logic [7:0] RST_PNUM  = PORT_ID[7:0];

  // Write channel state
  logic             aw_held_q;   // Address accepted, waiting for data
  logic             w_held_q;    // Data accepted, waiting for address
  logic [7:0]       awaddr_q;    // Held write address
  logic [31:0]      wdata_q;     // Held write data
  logic [3:0]       wstrb_q;     // Held write strobes
  logic             awready_q;
  logic             wready_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  // Read channel state
  logic             arready_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  // Capability fields
  logic [1:0]       aspm_q;
  logic [2:0]       l0s_q;
  logic [2:0]       l1_q;
  logic [7:0]       pnum_q;

  // Status and interrupt state
  logic [NE-1:0]    err_flag;    // Sticky error flags
  logic [NE-1:0]    err_evt;     // Error events this cycle
  logic [NE-1:0]    err_clr;     // Write-one clears this cycle
  logic             aux_sync_q;  // Synchronised aux power level
  logic [NE-1:0]    irq_stat_q;  // Interrupt status, clear on read
  logic [NE-1:0]    irq_stat_d;
  logic [NE-1:0]    irq_mask_q;  // Interrupt enables
  logic [NE-1:0]    irq_mask_d;
  logic             irq_q;

  // Handshake terms
  logic             aw_take;
  logic             w_take;
  logic             aw_have;
  logic             w_have;
  logic             do_write;
  logic [7:0]       waddr;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             aw_held_d;
  logic             w_held_d;
  logic             bvalid_d;
  logic             ar_take;
  logic             rvalid_d;
  logic [31:0]      rd_word;
  logic [1:0]       rd_resp;
  logic [1:0]       wr_resp;

  // Assembled register words
  logic [31:0]      devcs_word;
  logic [31:0]      linkcap_word;

  assign err_evt = {err_unsup, err_fatal, err_nonfatal, err_corr};

  // Aux power sense comes from a pin, so synchronise it
  // aux power sense
  pps_sync2 #(
    .RESET_VAL (`PPS_RST_AUX)
  ) u_aux_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (aux_power_pin),
    .sync_q   (aux_sync_q)
  );

  // One sticky flag per error source
  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++)
    begin : g_err
      pps_w1c_flag u_flag (
        .clock  (clock),
        .resetn (resetn),
        .set    (err_evt[gi]),
        .clr    (err_clr[gi]),
        .flag_q (err_flag[gi])
      );
    end
  endgenerate

  // Write handshake: address and data may arrive in either order
  always_comb
  begin
    aw_take   = s_axi_awvalid & awready_q;
    w_take    = s_axi_wvalid & wready_q;
    aw_have   = aw_held_q | aw_take;
    w_have    = w_held_q | w_take;
    do_write  = aw_have & w_have;
    waddr     = aw_held_q ? awaddr_q : s_axi_awaddr;
    wdata     = w_held_q ? wdata_q : s_axi_wdata;
    wstrb     = w_held_q ? wstrb_q : s_axi_wstrb;
    aw_held_d = aw_have & ~do_write;
    w_held_d  = w_have & ~do_write;
    bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);
  end

  // Write decode: clear strobes, mask update, response code
  always_comb
  begin
    err_clr    = '0;
    irq_mask_d = irq_mask_q;
    wr_resp    = pps_pkg::PPS_RESP_OKAY;
    if (do_write)
    begin
      unique case (waddr)
        `PPS_OFF_DEVCS:
        begin
          if (wstrb[`PPS_ST_BYTE_LANE])
            err_clr = wdata[`PPS_ST_ERR_LSB +: NE];
        end
        `PPS_OFF_LINKCAP:  wr_resp = pps_pkg::PPS_RESP_OKAY;
        `PPS_OFF_IRQ_STAT: wr_resp = pps_pkg::PPS_RESP_OKAY;
        `PPS_OFF_IRQ_MASK:
        begin
          if (wstrb[0])
            irq_mask_d = wdata[NE-1:0];
        end
        // Unmapped address
        default: wr_resp = pps_pkg::PPS_RESP_DECERR;
      endcase
    end
  end

  // Write channel registers; ready drops while a response waits
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= pps_pkg::PPS_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q  <= ~w_held_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (do_write)
        bresp_q <= wr_resp;
    end
  end

  // Device status word; control half lives elsewhere and reads zero
  always_comb
  begin
    devcs_word = 32'h00000000;
    devcs_word[`PPS_ST_ERR_LSB +: NE] = err_flag;
    devcs_word[`PPS_ST_AUX_BIT] = aux_sync_q;
    devcs_word[`PPS_ST_TP_BIT] = `PPS_RST_TP;
  end

  // Link capabilities word
  always_comb
  begin
    linkcap_word = {pnum_q, 2'h0, RST_BWN, `PPS_RST_DLL, 2'h0,
                    l1_q, l0s_q, aspm_q, RST_WIDTH, `PPS_RST_SPEED};
  end

  // Capability overrides; loader pulses ovr_valid with new fields
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      aspm_q <= `PPS_RST_ASPM;
      l0s_q  <= `PPS_RST_L0S;
      l1_q   <= `PPS_RST_L1;
      pnum_q <= RST_PNUM;
    end
    else if (ovr_valid)
    begin
      aspm_q <= ovr_aspm;
      l0s_q  <= ovr_l0s;
      l1_q   <= ovr_l1;
      pnum_q <= ovr_port_num;
    end
  end

  // Read handshake; one read in flight, answer next cycle
  always_comb
  begin
    ar_take  = s_axi_arvalid & arready_q;
    rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  end

  // Read mux
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_resp = pps_pkg::PPS_RESP_OKAY;
    unique case (s_axi_araddr)
      `PPS_OFF_DEVCS:    rd_word = devcs_word;
      `PPS_OFF_LINKCAP:  rd_word = linkcap_word;
      `PPS_OFF_IRQ_STAT: rd_word = {{(32-NE){1'b0}}, irq_stat_q};
      `PPS_OFF_IRQ_MASK: rd_word = {{(32-NE){1'b0}}, irq_mask_q};
      // Unmapped reads return zero with decode error
      default:           rd_resp = pps_pkg::PPS_RESP_DECERR;
    endcase
  end

  // Read channel registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= pps_pkg::PPS_RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_resp;
      end
    end
  end

  // Interrupt status: events set, a read clears; set wins a tie
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (ar_take && (s_axi_araddr == `PPS_OFF_IRQ_STAT))
      irq_stat_d = '0;
    irq_stat_d = irq_stat_d | err_evt;
  end

  // Interrupt registers; output follows next state to stay a flop
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= `PPS_RST_MASK;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;

endmodule

// ### verilog/pps_w1c_flag.sv
`timescale 1ns/100ps

// Sticky flag: hardware sets, software clears; set wins a tie
module pps_w1c_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Set and clear strobes
  input  wire logic set,
  input  wire logic clr,
  // Flag state
  output logic      flag_q
);

  // Set checked first so an event in the clearing cycle is kept
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      flag_q <= 1'b0;
    else if (set)
      flag_q <= 1'b1;
    else if (clr)
      flag_q <= 1'b0;
  end

endmodule
